// ---- pkg/cam_regs_map.vh ----
// register offsets, field positions and reset values of the camera register bank
`ifndef CAM_REGS_MAP_VH
`define CAM_REGS_MAP_VH
// ---------------------------------------------
// workspace offsets
// ---------------------------------------------
`define OFS_HBIN 16'h0204
`define OFS_MWIN_EN 16'h0208
`define OFS_R1_EN 16'h020c
`define OFS_MWIN_W 16'h0228
`define OFS_MWIN_X 16'h0248
`define OFS_R1_X 16'h024c
`define OFS_MWIN_H 16'h0268
`define OFS_MWIN_Y 16'h0288
`define OFS_VBIN 16'h0500
`define OFS_SCAN 16'h0504
// ---------------------------------------------
// information offsets
// ---------------------------------------------
`define OFS_TEMP 16'h6010
`define OFS_LINE 16'h608c
`define OFS_MAXEXP 16'h6090
`define OFS_MINEXP 16'h6094
`define OFS_EXP 16'h609c
`define OFS_FRAME 16'h60a0
`define OFS_DIMS 16'h60b0
`define OFS_GAIN 16'h60b4
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define POS_LINE 16
`define POS_VSIZE 16
`define POS_LUMA 12
`define POS_GMIN 24
`define POS_GMAX 25
`define POS_EMIN 28
`define POS_EMAX 29
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RST_BIN 3'h0
`define RST_SCAN 1'h0
`define RST_EN1 1'h0
`define RST_EN2 2'h0
`define RST_GEOM 12'h000
`endif

// ---- core/cam_status_regs.v ----
// apb register bank: camera information and image window workspace
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "cam_regs_map.vh"
// Behaviour
// RULE_01: min line time in upper sixteen bits
// RULE_02: min exposure, 24 bits, low bits
// RULE_03: max exposure 24 bits, tracks mode
// RULE_04: current exposure as 24 bits
// RULE_05: frame time 24 bits, top unused
// RULE_06: width low half, height high half
// RULE_07: gain field chosen by operating mode
// RULE_08: average luminance in bits 23..12
// RULE_09: gain flags 24/25, exposure 28/29
// RULE_10: temperature 10-bit signed, quarter degrees
// RULE_11: temperature two's complement, -128..127.75
// RULE_12: scan bit: progressive or centre partial
// RULE_13: vertical binning code selects factor
// RULE_14: horizontal binning, same code set
// RULE_15: main window enable bit zero
// RULE_16: main window geometry, four 12-bit
// RULE_17: region one enable: off/include/exclude
// RULE_18: region one x offset 12 bits
// RULE_19: unused bits zero, read-only ignore writes
// RULE_20: host avoids invalid enable/binning codes
// ---------------------------------------------
// bus timing
// ---------------------------------------------
// a setup cycle, then exactly one access cycle
// with pready high; prdata, pready and pslverr
// all come from flops, so none of them glitch
// unmapped addresses answer with pslverr and
// zero data, and no register changes
// writes to information addresses are ignored
module cam_status_regs #(
    parameter AW = 16, // apb address width
    parameter GW = 12 // window geometry width
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // timing status from the sensor core
    input wire [15:0] line_time_in,
    input wire [23:0] min_exp_in,
    input wire [23:0] max_exp_in,
    input wire [23:0] exposure_in,
    input wire [23:0] frame_time_in,
    input wire [15:0] hsize_in,
    input wire [15:0] vsize_in,
    // gain and luminance status
    input wire [11:0] manual_gain_tap1,
    input wire [11:0] calc_gain_tap1,
    input wire [11:0] calc_gain_tap2,
    input wire auto_gain_loop_on,
    input wire auto_exposure_loop_on,
    input wire tap_balance_on,
    input wire [11:0] luma_in,
    input wire gain_min_hit,
    input wire gain_max_hit,
    input wire exp_min_hit,
    input wire exp_max_hit,
    // temperature, signed quarter degrees
    input wire [9:0] temp_in,
    // workspace controls to the sensor core
    output reg scan_partial,
    output reg [2:0] vert_bin,
    output reg [2:0] horiz_bin,
    output reg main_window_en,
    output reg [GW-1:0] main_window_x,
    output reg [GW-1:0] main_window_w,
    output reg [GW-1:0] main_window_y,
    output reg [GW-1:0] main_window_h,
    output reg [1:0] region_window1_en,
    output reg [GW-1:0] region_window1_x,
    // one-cycle pulse: readout mode changed
    output reg mode_change
);

    // ---------------------------------------------
    // snapshot of the information inputs
    // ---------------------------------------------
    // inputs are sampled every cycle so the
    // registers track mode changes at once
    // the extra flop stage costs one cycle of
    // latency but keeps the read mux fed from
    // local flops instead of core-side logic
    reg [15:0] line_time; // pixels
    reg [23:0] min_exp; // microseconds
    reg [23:0] max_exp; // microseconds
    reg [23:0] cur_exp; // microseconds
    reg [23:0] frame_time; // microseconds
    reg [15:0] hsize; // pixels
    reg [15:0] vsize; // lines
    reg [11:0] gain_shown; // mode selected gain
    reg [11:0] luma; // average luminance
    reg [3:0] limit_flags; // gmin gmax emin emax
    reg [9:0] temp; // two's complement

    // ---------------------------------------------
    // bus decode helpers
    // ---------------------------------------------
    wire setup_phase; // first apb cycle
    wire wr_take; // write commit edge
    reg [31:0] next_prdata; // read word
    reg next_hit; // address is mapped
    reg [11:0] next_gain; // gain mux result

    assign setup_phase = psel & ~penable;
    assign wr_take = psel & penable & pready & pwrite;

    // ---------------------------------------------
    // gain source selection
    // ---------------------------------------------
    // tap balancing wins over the auto loops,
    // which win over the manual slider
    // several enables at once still show one source, never a mix
    always @* begin
        if (tap_balance_on) begin
            next_gain = calc_gain_tap2; // RULE_07
        end else if (auto_gain_loop_on | auto_exposure_loop_on) begin
            next_gain = calc_gain_tap1; // RULE_07
        end else begin
            next_gain = manual_gain_tap1; // RULE_07
        end
    end

    // ---------------------------------------------
    // status capture
    // ---------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            line_time <= 16'h0000;
            min_exp <= 24'h000000;
            max_exp <= 24'h000000;
            cur_exp <= 24'h000000;
            frame_time <= 24'h000000;
            hsize <= 16'h0000;
            vsize <= 16'h0000;
            gain_shown <= 12'h000;
            luma <= 12'h000;
            limit_flags <= 4'h0;
            temp <= 10'h000;
        end else begin
            line_time <= line_time_in; // RULE_01
            min_exp <= min_exp_in; // RULE_02
            max_exp <= max_exp_in; // RULE_03
            cur_exp <= exposure_in; // RULE_04
            frame_time <= frame_time_in; // RULE_05
            hsize <= hsize_in; // RULE_06
            vsize <= vsize_in; // RULE_06
            gain_shown <= next_gain; // RULE_07
            luma <= luma_in; // RULE_08
            // flags are levels from the core, shown as
            // sampled; the bank does not latch them
            // flag order matches the status word
            limit_flags <= {exp_max_hit, exp_min_hit,
                            gain_max_hit, gain_min_hit}; // RULE_09
            temp <= temp_in; // RULE_10
        end
    end

    // ---------------------------------------------
    // read data and address decode
    // ---------------------------------------------
    // every unused bit reads as zero; the word is
    // built in the setup cycle and held in a flop
    always @* begin
        next_prdata = 32'h00000000; // RULE_19
        next_hit = 1'b1;
        case (paddr[15:0])
            `OFS_LINE: begin
                // low half reads zero
                next_prdata[`POS_LINE +: 16] = line_time; // RULE_01
            end
            `OFS_MINEXP: begin
                next_prdata[23:0] = min_exp; // RULE_02
            end
            `OFS_MAXEXP: begin
                next_prdata[23:0] = max_exp; // RULE_03
            end
            `OFS_EXP: begin
                next_prdata[23:0] = cur_exp; // RULE_04
            end
            `OFS_FRAME: begin
                next_prdata[23:0] = frame_time; // RULE_05
            end
            `OFS_DIMS: begin
                next_prdata[15:0] = hsize; // RULE_06
                next_prdata[`POS_VSIZE +: 16] = vsize; // RULE_06
            end
            `OFS_GAIN: begin
                next_prdata[11:0] = gain_shown; // RULE_07
                next_prdata[`POS_LUMA +: 12] = luma; // RULE_08
                next_prdata[`POS_GMIN] = limit_flags[0]; // RULE_09
                next_prdata[`POS_GMAX] = limit_flags[1]; // RULE_09
                next_prdata[`POS_EMIN] = limit_flags[2]; // RULE_09
                next_prdata[`POS_EMAX] = limit_flags[3]; // RULE_09
            end
            `OFS_TEMP: begin
                // raw code, sign in bit 9; bits 31..10
                // stay zero, so software extends the sign
                next_prdata[9:0] = temp; // RULE_10 RULE_11
            end
            `OFS_SCAN: begin
                next_prdata[0] = scan_partial; // RULE_12
            end
            `OFS_VBIN: begin
                next_prdata[2:0] = vert_bin; // RULE_13
            end
            `OFS_HBIN: begin
                next_prdata[2:0] = horiz_bin; // RULE_14
            end
            `OFS_MWIN_EN: begin
                next_prdata[0] = main_window_en; // RULE_15
            end
            `OFS_MWIN_X: begin
                next_prdata[GW-1:0] = main_window_x; // RULE_16
            end
            `OFS_MWIN_W: begin
                next_prdata[GW-1:0] = main_window_w; // RULE_16
            end
            `OFS_MWIN_Y: begin
                next_prdata[GW-1:0] = main_window_y; // RULE_16
            end
            `OFS_MWIN_H: begin
                next_prdata[GW-1:0] = main_window_h; // RULE_16
            end
            `OFS_R1_EN: begin
                next_prdata[1:0] = region_window1_en; // RULE_17
            end
            `OFS_R1_X: begin
                next_prdata[GW-1:0] = region_window1_x; // RULE_18
            end
            default: begin
                // unmapped: zero data and an error
                next_hit = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------
    // apb handshake
    // ---------------------------------------------
    // no wait state: pready rises in the first
    // access cycle, which keeps prdata a flop
    // output without adding a cycle per access;
    // a setup right after the access edge is served
    // because pready is cleared on that same edge
    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= ~next_hit;
            if (pwrite) begin
                prdata <= 32'h00000000;
            end else begin
                prdata <= next_prdata;
            end
        end else begin
            // release after the access edge
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ---------------------------------------------
    // workspace writes
    // ---------------------------------------------
    // only the listed fields are stored; upper
    // bits and information addresses are dropped;
    // geometry is not range checked, an offset past
    // the imager edge is left to the core to clip
    always @(posedge clk) begin
        if (reset) begin
            scan_partial <= `RST_SCAN;
            vert_bin <= `RST_BIN;
            horiz_bin <= `RST_BIN;
            main_window_en <= `RST_EN1;
            main_window_x <= `RST_GEOM;
            main_window_w <= `RST_GEOM;
            main_window_y <= `RST_GEOM;
            main_window_h <= `RST_GEOM;
            region_window1_en <= `RST_EN2;
            region_window1_x <= `RST_GEOM;
        end else if (wr_take) begin
            case (paddr[15:0])
                `OFS_SCAN: begin
                    // 0 progressive, 1 centre partial
                    scan_partial <= pwdata[0]; // RULE_12
                end
                `OFS_VBIN: begin
                    // codes above 4 are stored as
                    // written; the core treats them
                    // as undefined
                    vert_bin <= pwdata[2:0]; // RULE_13 RULE_20
                end
                `OFS_HBIN: begin
                    horiz_bin <= pwdata[2:0]; // RULE_14 RULE_20
                end
                `OFS_MWIN_EN: begin
                    main_window_en <= pwdata[0]; // RULE_15
                end
                `OFS_MWIN_X: begin
                    main_window_x <= pwdata[GW-1:0]; // RULE_16
                end
                `OFS_MWIN_W: begin
                    main_window_w <= pwdata[GW-1:0]; // RULE_16
                end
                `OFS_MWIN_Y: begin
                    main_window_y <= pwdata[GW-1:0]; // RULE_16
                end
                `OFS_MWIN_H: begin
                    main_window_h <= pwdata[GW-1:0]; // RULE_16
                end
                `OFS_R1_EN: begin
                    // code 3 is not filtered
                    region_window1_en <= pwdata[1:0]; // RULE_17 RULE_20
                end
                `OFS_R1_X: begin
                    region_window1_x <= pwdata[GW-1:0]; // RULE_18
                end
                default: begin
                    // read-only or unmapped: no effect
                    scan_partial <= scan_partial; // RULE_19
                end
            endcase
        end
    end

    // ---------------------------------------------
    // mode change event
    // ---------------------------------------------
    // tells the core to recompute its limits
    // when a readout mode field really changes;
    // window geometry and region enables are not
    // modes, they leave the exposure limits alone;
    // the compare sees the value before the write
    always @(posedge clk) begin
        if (reset) begin
            mode_change <= 1'b0;
        end else if (wr_take) begin
            case (paddr[15:0])
                `OFS_SCAN: begin
                    mode_change <= pwdata[0] != scan_partial;
                end
                `OFS_VBIN: begin
                    mode_change <= pwdata[2:0] != vert_bin;
                end
                `OFS_HBIN: begin
                    mode_change <= pwdata[2:0] != horiz_bin;
                end
                default: begin
                    mode_change <= 1'b0;
                end
            endcase
        end else begin
            mode_change <= 1'b0;
        end
    end

endmodule

// ---- dv/cam_status_regs_monitor.sv ----
// concurrent checks on the camera register bank ports
`timescale 1ns/1ps
`include "cam_regs_map.vh"
module cam_status_regs_monitor #(
    parameter AW = 16,
    parameter GW = 12
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // workspace outputs
    input wire scan_partial,
    input wire [2:0] vert_bin,
    input wire [1:0] region_window1_en,
    input wire [GW-1:0] region_window1_x
);
    // ----------------
    // helpers
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // finished transfers, split by direction
    wire done = psel && penable && pready;
    wire wr = done && pwrite;
    wire rd = done && !pwrite;
    // write data seen one edge back, so a commit can be compared after it lands
    reg [31:0] last_wdata;
    always @(posedge clk) begin
        last_wdata <= pwdata;
    end
    // ----------------
    // checks
    // ----------------
    ack_timing_a: assert property (psel && !penable |=> pready && !$past(pready))
        else $error("ready not one cycle after setup");
    line_pad_a: assert property (rd && paddr == `OFS_LINE |-> prdata[15:0] == 16'h0000)
        else $error("line time low half set");
    exp_pad_a: assert property (rd && paddr inside {`OFS_MINEXP, `OFS_MAXEXP, `OFS_EXP, `OFS_FRAME} |->
        prdata[31:24] == 8'h00) else $error("time word top byte set");
    gain_pad_a: assert property (rd && paddr == `OFS_GAIN |-> {prdata[31:30], prdata[27:26]} == 4'h0)
        else $error("gain word spare bits set");
    temp_pad_a: assert property (rd && paddr == `OFS_TEMP |-> prdata[31:10] == 22'h0)
        else $error("temperature upper bits set");
    scan_wr_a: assert property (wr && paddr == `OFS_SCAN |=> scan_partial == last_wdata[0])
        else $error("scan select not updated");
    vbin_wr_a: assert property (wr && paddr == `OFS_VBIN |=> vert_bin == last_wdata[2:0])
        else $error("vertical binning not updated");
    r1en_wr_a: assert property (wr && paddr == `OFS_R1_EN |=> region_window1_en == last_wdata[1:0])
        else $error("region enable not updated");
    r1x_wr_a: assert property (wr && paddr == `OFS_R1_X |=> region_window1_x == last_wdata[GW-1:0])
        else $error("region offset not updated");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error reply carries data");
endmodule

bind cam_status_regs cam_status_regs_monitor #(.AW(AW), .GW(GW)) mon (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scan_partial, .vert_bin, .region_window1_en, .region_window1_x);

// ---- dv/cam_status_regs_tb.sv ----
// self-checking bench for the camera register bank
`timescale 1ns/1ps
`include "cam_regs_map.vh"
module cam_status_regs_tb;
    // ----------------
    // signals
    // ----------------
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 0, line_time_in = 0, hsize_in = 0, vsize_in = 0;
    logic [31:0] pwdata = 0, prdata, rd, wv [10];
    logic [23:0] min_exp_in = 0, max_exp_in = 0, exposure_in = 0, frame_time_in = 0;
    logic [11:0] manual_gain_tap1 = 0, calc_gain_tap1 = 0, calc_gain_tap2 = 0, luma_in = 0;
    logic auto_gain_loop_on = 0, auto_exposure_loop_on = 0, tap_balance_on = 0, gain_min_hit = 0;
    logic gain_max_hit = 0, exp_min_hit = 0, exp_max_hit = 0, pready, pslverr, er, scan_partial, main_window_en;
    logic [9:0] temp_in = 0;
    logic [2:0] vert_bin, horiz_bin;
    logic [11:0] main_window_x, main_window_w, main_window_y, main_window_h, region_window1_x;
    logic [1:0] region_window1_en;
    int bad_count = 0, num_checks = 0, n, mc = 0, m0;
    logic mode_change;
    // workspace offsets with their live bits, info offsets, temperature corners, holes
    logic [15:0] wa [10] = '{`OFS_HBIN, `OFS_MWIN_EN, `OFS_R1_EN, `OFS_MWIN_W, `OFS_MWIN_X, `OFS_R1_X,
        `OFS_MWIN_H, `OFS_MWIN_Y, `OFS_VBIN, `OFS_SCAN};
    logic [31:0] wm [10] = '{32'h7, 32'h1, 32'h3, 32'hfff, 32'hfff, 32'hfff, 32'hfff, 32'hfff, 32'h7, 32'h1};
    logic [15:0] ia [8] = '{`OFS_TEMP, `OFS_LINE, `OFS_MAXEXP, `OFS_MINEXP,
        `OFS_EXP, `OFS_FRAME, `OFS_DIMS, `OFS_GAIN};
    logic [9:0] tc [5] = '{10'h1ff, 10'h200, 10'h3ff, 10'h001, 10'h000};
    logic [15:0] ua [3] = '{16'h0206, 16'h6088, 16'h0210};

    cam_status_regs uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .line_time_in, .min_exp_in, .max_exp_in, .exposure_in, .frame_time_in, .hsize_in, .vsize_in,
        .manual_gain_tap1, .calc_gain_tap1, .calc_gain_tap2, .auto_gain_loop_on, .auto_exposure_loop_on,
        .tap_balance_on, .luma_in, .gain_min_hit, .gain_max_hit, .exp_min_hit, .exp_max_hit, .temp_in,
        .scan_partial, .vert_bin, .horiz_bin, .main_window_en, .main_window_x, .main_window_w, .main_window_y,
        .main_window_h, .region_window1_en, .region_window1_x, .mode_change);

    // 250 MHz
    always #2 clk = ~clk;

    // count mode change pulses as the design shows them
    always @(posedge clk) begin
        if (mode_change === 1'b1) mc <= mc + 1;
    end

    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer; bus is left in access so a setup may follow at once
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk("wait", n, 1);
    endtask
    task automatic idle(input int c);
        psel <= 0;
        penable <= 0;
        repeat (c) @(posedge clk);
    endtask
    // read word expected from the status inputs
    function automatic logic [31:0] info(input logic [15:0] a);
        logic [11:0] g;
        g = tap_balance_on ? calc_gain_tap2 : (auto_gain_loop_on | auto_exposure_loop_on) ? calc_gain_tap1
            : manual_gain_tap1;
        case (a)
            `OFS_TEMP: return {22'h0, temp_in};
            `OFS_LINE: return {line_time_in, 16'h0000};
            `OFS_MAXEXP: return {8'h00, max_exp_in};
            `OFS_MINEXP: return {8'h00, min_exp_in};
            `OFS_EXP: return {8'h00, exposure_in};
            `OFS_FRAME: return {8'h00, frame_time_in};
            `OFS_DIMS: return {vsize_in, hsize_in};
            default: return {2'h0, exp_max_hit, exp_min_hit, 2'h0, gain_max_hit, gain_min_hit, luma_in, g};
        endcase
    endfunction
    // control output that belongs to workspace entry i
    function automatic logic [31:0] port(input int i);
        case (i)
            0: return 32'(horiz_bin);
            1: return 32'(main_window_en);
            2: return 32'(region_window1_en);
            3: return 32'(main_window_w);
            4: return 32'(main_window_x);
            5: return 32'(region_window1_x);
            6: return 32'(main_window_h);
            7: return 32'(main_window_y);
            8: return 32'(vert_bin);
            default: return 32'(scan_partial);
        endcase
    endfunction
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------
    // sequence
    // ----------------
    initial begin
        n = $urandom(3);
        repeat (2) @(posedge clk);
        reset <= 0;
        idle(1);
        for (int i = 0; i < 10; i++) begin
            xfer(0, wa[i], 0);
            chk("cleared", rd, 32'h0);
        end
        // random pass, then all ones (bits 2:1 cleared on the narrow fields) to show spare bits are dropped
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 10; i++) begin
                wv[i] = r ? 32'hffffffff : $urandom;
                if (wm[i] < 8) wv[i][2:1] = 2'h0;
                xfer(1, wa[i], wv[i]);
            end
            idle(1);
            for (int i = 0; i < 10; i++) begin
                xfer(0, wa[i], 0);
                chk("readback", rd, wv[i] & wm[i]);
                chk("control", port(i), wv[i] & wm[i]);
            end
            idle(1);
        end
        // every documented code of the binning and region enable fields
        for (int k = 0; k < 5; k++) begin
            m0 = mc;
            xfer(1, `OFS_VBIN, k);
            xfer(1, `OFS_HBIN, k);
            xfer(1, `OFS_R1_EN, k % 3);
            idle(1);
            chk("vbin", 32'(vert_bin), k);
            chk("hbin", 32'(horiz_bin), k);
            chk("region", 32'(region_window1_en), k % 3);
            chk("mode", mc - m0, 2);
        end
        // rewriting the code already held is not a mode change
        m0 = mc;
        xfer(1, `OFS_VBIN, 4);
        idle(1);
        chk("same", mc - m0, 0);
        // every gain mode; odd passes try to overwrite the info words first
        for (int m = 0; m < 8; m++) begin
            {auto_gain_loop_on, auto_exposure_loop_on, tap_balance_on} <= 3'(m);
            {gain_min_hit, gain_max_hit, exp_min_hit, exp_max_hit} <= 4'($urandom);
            temp_in <= m < 5 ? tc[m] : 10'($urandom);
            {min_exp_in, max_exp_in, exposure_in, frame_time_in} <= {$urandom, $urandom, $urandom};
            {line_time_in, hsize_in, vsize_in, luma_in, manual_gain_tap1, calc_gain_tap1, calc_gain_tap2} <=
                {$urandom, $urandom, $urandom};
            idle(3);
            for (int i = 0; i < 8; i++) begin
                xfer(m[0], ia[i], $urandom);
                if (m[0]) begin
                    chk("roerr", er, 0);
                    xfer(0, ia[i], 0);
                end
                chk("info", rd, info(ia[i]));
            end
            idle(1);
        end
        // holes in the map answer with an error and change nothing
        for (int j = 0; j < 3; j++) begin
            xfer(!j[0], ua[j], 32'hffffffff);
            chk("error", 32'(er), 32'h1);
            chk("errdata", rd, 32'h0);
        end
        xfer(0, `OFS_HBIN, 0);
        chk("unchanged", rd, 32'h4);
        idle(1);
        complete_run();
    end

    // hang guard
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end
endmodule
